// File: include/tml_pkg.sv
// constants and types shared by the torque-mode speed limiter
// assumes a single 50 MHz clock and word-aligned Avalon-MM register access
package tml_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CTRL_PERIOD_US = 100;
   localparam int unsigned CTRL_CYCLES = CLK_HZ / 1_000_000 * CTRL_PERIOD_US;
   localparam int unsigned TICKS_PER_MS = 1000 / CTRL_PERIOD_US;
   localparam int unsigned FILT_MAX_MS = 1000;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDR_CTRL = 6'h00;
   localparam logic [5:0] ADDR_AI_CFG = 6'h04;
   localparam logic [5:0] ADDR_FILT = 6'h08;
   localparam logic [5:0] ADDR_LIMIT = 6'h0C;
   localparam logic [5:0] ADDR_BIAS = 6'h10;
   localparam logic [5:0] ADDR_DIN_LO = 6'h14;
   localparam logic [5:0] ADDR_DIN_HI = 6'h18;
   localparam logic [5:0] ADDR_STATUS = 6'h1C;
   localparam logic [5:0] ADDR_REF = 6'h20;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_TORQUE_BIT = 0;
   localparam int unsigned CTRL_SRC_BIT = 1;
   localparam int unsigned AI1_LVL_LSB = 0;
   localparam int unsigned AI2_LVL_LSB = 2;
   localparam int unsigned AI2_FN_LSB = 8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] AI_CFG_RST = 32'h0000_0F00;
   localparam logic [31:0] FILT_RST = 32'h0000_0000;
   localparam logic [31:0] LIMIT_RST = 32'h0000_1000;
   localparam logic [31:0] BIAS_RST = 32'h0000_0000;
   localparam logic [31:0] DIN_RST = 32'h0000_0000;

   // ----------------------------------------------------------------
   // function codes and scaling (16'h1000 = 100 %, 10 V or 20 mA)
   // ----------------------------------------------------------------
   localparam logic [7:0] FN_ADD_LIMIT = 8'h0C;
   localparam logic [7:0] FN_TORQUE_REF = 8'h0F;
   localparam logic [7:0] FN_TORQUE_COMP = 8'h10;
   localparam logic [7:0] DI_TORQUE_MODE = 8'h2C;
   localparam logic [7:0] DI_NEG_TORQUE = 8'h2D;
   localparam logic signed [17:0] CUR_ZERO = 18'sh0_0333;
   localparam logic signed [17:0] FULL_MAX = 18'sh0_7FFF;
   localparam logic signed [17:0] FULL_MIN = -18'sh0_8000;
   localparam int unsigned KP_SHIFT = 2;

   typedef enum logic [1:0] {RG_BAND, RG_OVER, RG_UNDER} tml_region_t;

endpackage

// File: hdl/tml_ref_filter.sv
// first-order low-pass on the torque reference, one step per control tick
// assumes tick_i is a one-cycle pulse from the same clock domain
`timescale 1ns/100ps
module tml_ref_filter #(
   parameter int W = 16
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic tick_i,
   input wire logic [3:0] shift_i,
   input wire logic signed [W-1:0] x_i,
   output logic signed [W-1:0] y_o
);

   // 16 fraction bits keep small steps from stalling at long time constants
   logic signed [W+16:0] acc_q;
   logic signed [W+16:0] target;
   logic signed [W+16:0] step;

   always_comb begin
      target = {x_i[W-1], x_i, 16'h0000};
      step = (target - acc_q) >>> shift_i;
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         acc_q <= '0;
      end else if (tick_i) begin
         if (shift_i == 4'h0) begin
            acc_q <= target;
         end else begin
            acc_q <= acc_q + step;
         end
      end
   end

   assign y_o = acc_q[W+15:16];

endmodule

// File: hdl/tml_torque_limiter.sv
// torque-mode reference path and speed limiter with Avalon-MM registers
// assumes analog samples arrive already digitised on ref_clk_i;
// digital inputs are raw pins and are synchronised here
//
// Overview of operation
// R1: second analog input is torque reference at code 15, compensation at 16.
// R2: no register or keypad path writes the torque reference.
// R3: torque sign follows analog reference polarity, not run direction.
// R4: active digital input coded 45 forces the torque reference negative.
// R5: second input level 0/2 is 0-10 V, level 1/3 is 4-20 mA.
// R6: torque reference is low-pass filtered with a settable time constant.
// R7: limit source 0 takes the speed limit from the analog inputs.
// R8: limit source 1 takes the stored speed limit value.
// R9: second input coded 12 is added to the first as speed limit.
// R10: first input level 2/3 is bipolar, 0/1 positive only.
// R11: positive limit bounds -bias..limit+bias; negative limit-bias..bias.
// R12: zero bias clamps speed at zero against the limit direction.
// R13: bias is symmetric, in percent of maximum output frequency.
// R14: speed inside the band commands torque from the reference.
// R15: speed above the upper bound commands opposing negative torque.
// R16: speed below the lower bound commands opposing forward torque.
// R17: user gives reference and limit equal signs winding, opposite unwinding.
// R18: torque mode when selected or when an input coded 44 is active.
// R19: filter time accepts 0 to 1000 ms.
// R20: everything is recomputed once per control tick and then held.
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module tml_torque_limiter #(
   parameter int unsigned CTRL_CYCLES = tml_pkg::CTRL_CYCLES,
   parameter int unsigned N_DIN = 8
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic signed [15:0] analog_input_one_i,
   input wire logic signed [15:0] analog_input_two_i,
   input wire logic [N_DIN-1:0] din_i,
   input wire logic signed [15:0] motor_speed_i,
   output logic signed [15:0] torque_cmd_o,
   output logic signed [15:0] torque_comp_o,
   output logic torque_mode_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
      logic signed [15:0] r;
      r = v[15:0];
      if (v > tml_pkg::FULL_MAX) begin
         r = 16'sh7FFF;
      end else if (v < tml_pkg::FULL_MIN) begin
         r = -16'sh8000;
      end
      return r;
   endfunction

   // any synchronised input whose code byte matches is active
   function automatic logic din_hit(input logic [N_DIN-1:0] din,
                                    input logic [63:0] map,
                                    input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_DIN && i < 8; i++) begin
         if (din[i] && map[8*i +: 8] == code) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // power-of-two nearest above the time constant in control ticks
   function automatic logic [3:0] tau_shift(input logic [31:0] ms);
      logic [31:0] ticks;
      logic [3:0] s;
      ticks = (ms > tml_pkg::FILT_MAX_MS) ? tml_pkg::FILT_MAX_MS : ms;
      ticks = ticks * tml_pkg::TICKS_PER_MS;
      s = 4'h0;
      for (int i = 0; i < 15; i++) begin
         if ((32'h0000_0001 << i) < ticks) begin
            s = 4'(i + 1);
         end
      end
      return s;
   endfunction

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [31:0] ai_cfg_q;
   logic [31:0] filt_q;
   logic [31:0] speed_limit_value_q;
   logic [31:0] bias_q;
   logic [31:0] din_lo_q;
   logic [31:0] din_hi_q;
   logic wr_go;
   logic [31:0] rdata_d;
   logic signed [15:0] tref_f;
   logic signed [15:0] limit_q;
   logic neg_q;
   tml_pkg::tml_region_t region_q;

   // request completes on the second edge: waitrequest is low one cycle
   assign wr_go = avs_write_i && !avs_waitrequest_o;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b0;
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (avs_address_i == tml_pkg::ADDR_CTRL) begin
         rdata_d = ctrl_q;
      end else if (avs_address_i == tml_pkg::ADDR_AI_CFG) begin
         rdata_d = ai_cfg_q;
      end else if (avs_address_i == tml_pkg::ADDR_FILT) begin
         rdata_d = filt_q;
      end else if (avs_address_i == tml_pkg::ADDR_LIMIT) begin
         rdata_d = speed_limit_value_q;
      end else if (avs_address_i == tml_pkg::ADDR_BIAS) begin
         rdata_d = bias_q;
      end else if (avs_address_i == tml_pkg::ADDR_DIN_LO) begin
         rdata_d = din_lo_q;
      end else if (avs_address_i == tml_pkg::ADDR_DIN_HI) begin
         rdata_d = din_hi_q;
      end else if (avs_address_i == tml_pkg::ADDR_STATUS) begin
         rdata_d = {torque_cmd_o, 12'h000, region_q, neg_q, torque_mode_o};
      end else if (avs_address_i == tml_pkg::ADDR_REF) begin
         rdata_d = {limit_q, tref_f};
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && avs_waitrequest_o) begin
         avs_readdata_o <= rdata_d;
      end
   end

   // no writable torque reference exists: it only comes from analog R2
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q <= tml_pkg::CTRL_RST;
         ai_cfg_q <= tml_pkg::AI_CFG_RST;
         filt_q <= tml_pkg::FILT_RST;
         speed_limit_value_q <= tml_pkg::LIMIT_RST;
         bias_q <= tml_pkg::BIAS_RST;
         din_lo_q <= tml_pkg::DIN_RST;
         din_hi_q <= tml_pkg::DIN_RST;
      end else if (wr_go) begin
         if (avs_address_i == tml_pkg::ADDR_CTRL) begin
            ctrl_q <= be_merge(ctrl_q, avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == tml_pkg::ADDR_AI_CFG) begin
            ai_cfg_q <= be_merge(ai_cfg_q, avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == tml_pkg::ADDR_FILT) begin
            filt_q <= be_merge(filt_q, avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == tml_pkg::ADDR_LIMIT) begin
            speed_limit_value_q <= be_merge(speed_limit_value_q,
                                            avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == tml_pkg::ADDR_BIAS) begin
            bias_q <= be_merge(bias_q, avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == tml_pkg::ADDR_DIN_LO) begin
            din_lo_q <= be_merge(din_lo_q, avs_writedata_i, avs_byteenable_i);
         end else if (avs_address_i == tml_pkg::ADDR_DIN_HI) begin
            din_hi_q <= be_merge(din_hi_q, avs_writedata_i, avs_byteenable_i);
         end
      end
   end

   // ----------------------------------------------------------------
   // digital input synchroniser and control tick
   // ----------------------------------------------------------------
   logic [N_DIN-1:0] din_s1_q;
   logic [N_DIN-1:0] din_s2_q;
   logic [$clog2(CTRL_CYCLES)-1:0] cnt_q;
   logic tick_q;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         din_s1_q <= '0;
         din_s2_q <= '0;
      end else begin
         din_s1_q <= din_i;
         din_s2_q <= din_s1_q;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (cnt_q == ($clog2(CTRL_CYCLES))'(CTRL_CYCLES - 1)) begin
         cnt_q <= '0;
         tick_q <= 1'b1; // R20
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // analog conditioning and reference selection
   // ----------------------------------------------------------------
   logic [7:0] ai2_fn;
   logic [1:0] ai1_lvl;
   logic [1:0] ai2_lvl;
   logic [63:0] din_map;
   logic signed [17:0] ai1_v;
   logic signed [17:0] ai2_v;
   logic signed [17:0] cur_v;
   logic signed [15:0] tref_raw;
   logic neg_d;
   logic mode_d;

   assign ai2_fn = ai_cfg_q[tml_pkg::AI2_FN_LSB +: 8];
   assign ai1_lvl = ai_cfg_q[tml_pkg::AI1_LVL_LSB +: 2];
   assign ai2_lvl = ai_cfg_q[tml_pkg::AI2_LVL_LSB +: 2];
   assign din_map = {din_hi_q, din_lo_q};
   assign neg_d = din_hit(din_s2_q, din_map, tml_pkg::DI_NEG_TORQUE);
   assign mode_d = ctrl_q[tml_pkg::CTRL_TORQUE_BIT] ||
                   din_hit(din_s2_q, din_map, tml_pkg::DI_TORQUE_MODE); // R18

   always_comb begin
      // positive-only range drops negative samples R10
      ai1_v = 18'(analog_input_one_i);
      if (!ai1_lvl[1] && ai1_v < 0) begin
         ai1_v = '0;
      end
      // 4 mA offset removed, 16 mA span stretched to full scale R5
      cur_v = 18'(((18'(analog_input_two_i) - tml_pkg::CUR_ZERO) * 5) >>> 2);
      if (ai2_lvl[0]) begin
         ai2_v = (cur_v < 0) ? 18'sh0_0000 : cur_v;
      end else begin
         ai2_v = 18'(analog_input_two_i);
      end
      // sign of the sample gives direction R3
      tref_raw = (ai2_fn == tml_pkg::FN_TORQUE_REF) ? sat16(ai2_v) : '0; // R1
      if (neg_d && tref_raw > 0) begin
         tref_raw = -tref_raw; // R4
      end
   end

   tml_ref_filter #(
      .W(16)
   ) u_filter (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .tick_i(tick_q),
      .shift_i(tau_shift(filt_q)), // R6 R19
      .x_i(tref_raw),
      .y_o(tref_f)
   );

   // ----------------------------------------------------------------
   // speed band and torque override
   // ----------------------------------------------------------------
   logic signed [17:0] limit_d;
   logic signed [17:0] bias_v;
   logic signed [17:0] upper;
   logic signed [17:0] lower;
   logic signed [17:0] spd;
   logic signed [15:0] cmd_d;
   tml_pkg::tml_region_t region_d;

   always_comb begin
      if (ctrl_q[tml_pkg::CTRL_SRC_BIT]) begin
         limit_d = 18'(signed'(speed_limit_value_q[15:0])); // R8
      end else if (ai2_fn == tml_pkg::FN_ADD_LIMIT) begin
         limit_d = 18'(sat16(ai1_v + ai2_v)); // R9
      end else begin
         limit_d = ai1_v; // R7
      end
      // bias counts in the same units as speed: 16'h1000 is max frequency
      bias_v = 18'(signed'({1'b0, bias_q[14:0]})); // R13
      spd = 18'(motor_speed_i);
      if (limit_d >= 0) begin
         upper = 18'(sat16(limit_d + bias_v)); // R11
         lower = -bias_v;
      end else begin
         upper = bias_v;
         lower = 18'(sat16(limit_d - bias_v));
      end
      // zero bias makes the opposite bound zero, clamping speed there R12
      if (spd > upper) begin
         region_d = tml_pkg::RG_OVER;
         cmd_d = sat16(-((spd - upper) <<< tml_pkg::KP_SHIFT)); // R15
      end else if (spd < lower) begin
         region_d = tml_pkg::RG_UNDER;
         cmd_d = sat16((lower - spd) <<< tml_pkg::KP_SHIFT); // R16
      end else begin
         region_d = tml_pkg::RG_BAND;
         cmd_d = tref_f; // R14
      end
   end

   // winding vs unwinding is chosen by the signs the user sets R17
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         torque_cmd_o <= '0;
         torque_comp_o <= '0;
         torque_mode_o <= 1'b0;
         limit_q <= '0;
         neg_q <= 1'b0;
         region_q <= tml_pkg::RG_BAND;
      end else if (tick_q) begin
         torque_mode_o <= mode_d;
         torque_cmd_o <= mode_d ? cmd_d : 16'sh0000; // R18 R20
         torque_comp_o <= (ai2_fn == tml_pkg::FN_TORQUE_COMP) ?
                          sat16(ai2_v) : 16'sh0000; // R1
         limit_q <= sat16(limit_d);
         neg_q <= neg_d;
         region_q <= region_d;
      end
   end

endmodule

// File: tb/tml_assertions.sv
// port checker for the torque limiter, bound to every instance
// assumes the single ref_clk_i domain and the async active low reset
`timescale 1ns/100ps
module tml_assertions #(
   parameter int unsigned CTRL_CYCLES = 20
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic signed [15:0] torque_cmd_o,
   input wire logic torque_mode_o
);
   // ---------------------------------------------
   // helper: cycles since the control outputs moved
   // ---------------------------------------------
   logic [16:0] prev_q;
   int unsigned gap_q;
   logic moved;
   assign moved = {torque_mode_o, torque_cmd_o} != prev_q;
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev_q <= '0;
         gap_q <= 0;
      end else begin
         prev_q <= {torque_mode_o, torque_cmd_o};
         // saturate: no wrap on long idle
         gap_q <= moved ? 0 : (gap_q < CTRL_CYCLES ? gap_q + 1 : gap_q);
      end
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   property p_wait_one;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   property p_answer;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   property p_no_spont;
      $fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i);
   endproperty
   property p_spd_zero;
      !torque_mode_o |-> torque_cmd_o == 16'sh0000;
   endproperty
   property p_hold;
      moved |-> gap_q >= CTRL_CYCLES - 1;
   endproperty
   property p_unmapped;
      avs_read_i && avs_waitrequest_o && avs_address_i > 6'h20
         |=> avs_readdata_o == 32'h0000_0000;
   endproperty
   property p_status;
      avs_read_i && avs_waitrequest_o && avs_address_i == 6'h1C
         |=> avs_readdata_o[31:16] == $past(torque_cmd_o)
             && avs_readdata_o[0] == $past(torque_mode_o);
   endproperty
   property p_rd_hold;
      !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o);
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low for more than one cycle");
   a_answer: assert property (p_answer)
      else $error("bus request not answered next cycle");
   a_no_spont: assert property (p_no_spont)
      else $error("waitrequest dropped with no request");
   a_spd_zero: assert property (p_spd_zero)
      else $error("torque command nonzero in speed control");
   a_hold: assert property (p_hold)
      else $error("control outputs moved between ticks");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned nonzero data");
   a_status: assert property (p_status)
      else $error("status word disagrees with outputs");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data changed without a read");
   cover property (avs_write_i && !avs_waitrequest_o);
   cover property (avs_read_i && !avs_waitrequest_o);
   cover property (torque_mode_o && torque_cmd_o < 16'sh0000);
   cover property ($rose(torque_mode_o));
endmodule

bind tml_torque_limiter tml_assertions #(.CTRL_CYCLES(CTRL_CYCLES)) u_chk (
   .ref_clk_i(ref_clk_i),
   .resetn_i(resetn_i),
   .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .torque_cmd_o(torque_cmd_o),
   .torque_mode_o(torque_mode_o)
);

// File: tb/tml_motor_model.sv
// analog sources and load-driven motor speed seen by the limiter
// assumes the bench sets targets; samples appear one clock later
`timescale 1ns/100ps
module tml_motor_model (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic signed [15:0] ai1_set_i,
   input wire logic signed [15:0] ai2_set_i,
   input wire logic signed [15:0] spd_set_i,
   output logic signed [15:0] analog_input_one_o,
   output logic signed [15:0] analog_input_two_o,
   output logic signed [15:0] motor_speed_o
);
   // speed is imposed by the line load, so it follows the bench target
   always @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         analog_input_one_o <= 16'sh0000;
         analog_input_two_o <= 16'sh0000;
         motor_speed_o <= 16'sh0000;
      end else begin
         analog_input_one_o <= ai1_set_i;
         analog_input_two_o <= ai2_set_i;
         motor_speed_o <= spd_set_i;
      end
   end
endmodule

// File: tb/torque_mode_speed_limiter_bench.sv
// self-checking bench for the torque limiter, 50 MHz, short tick
// assumes tml_motor_model as far side and the bound checker
`timescale 1ns/100ps
module torque_mode_speed_limiter_bench;
   localparam int CC = 20;
   localparam logic [31:0] RV [6] = '{tml_pkg::CTRL_RST,
      tml_pkg::AI_CFG_RST, tml_pkg::FILT_RST, tml_pkg::LIMIT_RST,
      tml_pkg::BIAS_RST, tml_pkg::DIN_RST};
   localparam int LM [7] = '{4096, 4096, 4096, -4096, -4096, 4096, 4096};
   localparam int BS [7] = '{1024, 1024, 1024, 1024, 1024, 0, 1024};
   localparam int SP [7] = '{5376, -1280, 5120, 1280, -5376, -16, 32767};
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [5:0] addr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata, q;
   logic wreq, tmode;
   logic [7:0] din = 8'h00;
   logic signed [15:0] ai1 = 0, ai2 = 0, spd = 0;
   logic signed [15:0] a1, a2, sp, tcmd, tcomp;
   int n_fail = 0;
   int checks = 0;
   integer seed = 32'h14d2;
   int v;

   always #10 ref_clk_i = ~ref_clk_i;

   tml_motor_model u_far (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .ai1_set_i(ai1), .ai2_set_i(ai2), .spd_set_i(spd),
      .analog_input_one_o(a1), .analog_input_two_o(a2),
      .motor_speed_o(sp));
   tml_torque_limiter #(.CTRL_CYCLES(CC)) dut (.ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .analog_input_one_i(a1),
      .analog_input_two_i(a2), .din_i(din), .motor_speed_i(sp),
      .torque_cmd_o(tcmd), .torque_comp_o(tcomp), .torque_mode_o(tmode));

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         n_fail++;
         print_verdict();
      end
   endtask
   task automatic tk(input int n);
      repeat (n * CC + 3) @(posedge ref_clk_i);
   endtask
   task automatic drive(input int x1, input int x2, input int xs);
      ai1 <= 16'(x1);
      ai2 <= 16'(x2);
      spd <= 16'(xs);
   endtask
   // band edges per limit sign, override saturated
   function automatic logic signed [15:0] ovr(int s, int l, int b, int r);
      int hi, lo, t;
      hi = l >= 0 ? l + b : b;
      lo = l >= 0 ? -b : l - b;
      t = s > hi ? (hi - s) * 4 : (s < lo ? (lo - s) * 4 : r);
      t = t > 32767 ? 32767 : (t < -32768 ? -32768 : t);
      return 16'(t);
   endfunction

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   initial begin
      repeat (5) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         bus(0, 6'(4 * i), 0);
         chk("reset value", q, RV[i]);
      end
      bus(1, 6'h24, 32'h0000_FFFF);
      bus(0, 6'h24, 0);
      chk("unmapped", q, 0);
      bus(1, tml_pkg::ADDR_REF, 32'h0000_FFFF);
      bus(0, tml_pkg::ADDR_REF, 0);
      chk("ref word", q, 0);
      drive(0, 2048, 0);
      tk(3);
      chk("speed mode torque", tcmd, 0);
      $display("test registers done");
      bus(1, tml_pkg::ADDR_CTRL, 32'h0000_0003);
      bus(1, tml_pkg::ADDR_BIAS, 32'h0000_0400);
      for (int i = 0; i < 6; i++) begin
         v = $random(seed) % 4096;
         drive(0, v, $random(seed) % 1024);
         tk(3);
         chk("band torque", tcmd, v);
      end
      bus(0, tml_pkg::ADDR_REF, 0);
      chk("stored limit", q[31:16], 16'h1000);
      $display("test band done");
      for (int i = 0; i < 7; i++) begin
         bus(1, tml_pkg::ADDR_LIMIT, 32'(16'(LM[i])));
         bus(1, tml_pkg::ADDR_BIAS, 32'(BS[i]));
         drive(0, 256, SP[i]);
         tk(3);
         chk("override", tcmd, ovr(SP[i], LM[i], BS[i], 256));
      end
      bus(0, tml_pkg::ADDR_STATUS, 0);
      chk("status", q, 32'h8000_0005);
      $display("test override done");
      for (int i = 0; i < 4; i++) begin
         bus(1, tml_pkg::ADDR_AI_CFG, 32'h0000_0F00 | 32'(i << 2));
         drive(0, 512, 0);
         tk(3);
         chk("input level", tcmd, i[0] ? 0 : 512);
      end
      bus(1, tml_pkg::ADDR_AI_CFG, 32'h0000_1000);
      drive(0, 1280, 0);
      tk(3);
      chk("compensation", tcomp, 16'sh0500);
      bus(1, tml_pkg::ADDR_AI_CFG, 32'h0000_0F00);
      bus(1, tml_pkg::ADDR_DIN_LO, 32'h0000_2C2D);
      din <= 8'h01;
      for (int i = 0; i < 2; i++) begin
         drive(0, i ? -768 : 512, 0);
         tk(3);
         chk("negated torque", tcmd, i ? -768 : -512);
      end
      bus(1, tml_pkg::ADDR_CTRL, 32'h0000_0002);
      din <= 8'h02;
      tk(3);
      chk("input torque mode", tmode, 1);
      din <= 8'h00;
      tk(3);
      chk("speed mode", tmode, 0);
      $display("test inputs done");
      bus(1, tml_pkg::ADDR_CTRL, 32'h0000_0001);
      drive(-2048, 0, 0);
      tk(3);
      bus(0, tml_pkg::ADDR_REF, 0);
      chk("unipolar limit", q[31:16], 0);
      bus(1, tml_pkg::ADDR_AI_CFG, 32'h0000_0F02);
      tk(3);
      bus(0, tml_pkg::ADDR_REF, 0);
      chk("bipolar limit", q[31:16], 16'hF800);
      bus(1, tml_pkg::ADDR_AI_CFG, 32'h0000_0C02);
      drive(-2048, 768, 0);
      tk(3);
      bus(0, tml_pkg::ADDR_REF, 0);
      chk("summed limit", q[31:16], 16'hFB00);
      $display("test limit source done");
      bus(1, tml_pkg::ADDR_CTRL, 32'h0000_0003);
      bus(1, tml_pkg::ADDR_AI_CFG, 32'h0000_0F00);
      bus(1, tml_pkg::ADDR_FILT, 32'h0000_03E8);
      bus(0, tml_pkg::ADDR_FILT, 0);
      chk("filter time", q, 32'h0000_03E8);
      bus(1, tml_pkg::ADDR_FILT, 32'h0000_0001);
      drive(0, 4096, 0);
      tk(3);
      chk("filter lag", tcmd > 0 && tcmd < 16'sh1000, 1);
      $display("test filter done");
      resetn_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      chk("mode after reset", tmode, 0);
      bus(0, tml_pkg::ADDR_FILT, 0);
      chk("filter after reset", q, tml_pkg::FILT_RST);
      $display("test second reset done");
      print_verdict();
   end
endmodule
